// ===== src/pbs_cfg.svh
// Purpose: Register indices, field positions and reset values of the port and boot-select bank
// Assumes: APB byte address = index * 4, word-aligned registers
// Notes:   Included by the APB slave, port group and bank modules, not by the package
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

// Register indices (byte address is index * 4)
`define PBS_IDX_PORT_E_DATA   3'h0
`define PBS_IDX_PORT_E_DIR    3'h1
`define PBS_IDX_PORT_E_ASSIGN 3'h2
`define PBS_IDX_PORT_F_DATA   3'h3
`define PBS_IDX_PORT_F_DIR    3'h4
`define PBS_IDX_PORT_F_ASSIGN 3'h5
`define PBS_IDX_PORT_C_DATA   3'h6
`define PBS_IDX_BOOT_BASE     3'h7

// Address decode: index bits and the span of the bank
`define PBS_IDX_MSB           4
`define PBS_IDX_LSB           2
`define PBS_SPAN_MSB          31
`define PBS_SPAN_LSB          5

// Field positions
`define PBS_PORT_WIDTH        8
`define PBS_PORT_C_WIDTH      7
`define PBS_BASE_MSB          15
`define PBS_BASE_LSB          3
`define PBS_SIZE_MSB          2
`define PBS_SIZE_LSB          0

// Reset values
`define PBS_DIR_RESET         8'h00
`define PBS_PORT_C_RESET      7'h7F
`define PBS_BASE_RESET        13'h0000
`define PBS_SIZE_RESET        3'h7

`endif

// ===== src/pbs_pkg.sv
// Purpose: Types shared by the port and boot-select bank
// Assumes: Constants live in pbs_cfg.svh
// Notes:   One-hot state codes are written out
package pbs_pkg;

	typedef enum logic [1:0]
	{
		PBS_IDLE   = 2'b01,
		PBS_ANSWER = 2'b10
	} pbs_apb_state_t;

	typedef logic [2:0] pbs_index_t;

endpackage

// ===== src/pbs_regbus_if.sv
// Purpose: Internal write strobe and read path between the APB slave and the registers
// Assumes: One clock domain
// Notes:   wrStrobe is a one-cycle pulse at the completing APB edge
interface pbs_regbus_if;
	import pbs_pkg::*;

	logic        wrStrobe;
	pbs_index_t  index;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport bus
	(
		output wrStrobe,
		output index,
		output wdata,
		input  rdata
	);

	modport regs
	(
		input  wrStrobe,
		input  index,
		input  wdata,
		output rdata
	);
endinterface

// ===== src/pbs_apb_slave.sv
// Purpose: APB slave front end with one wait state
// Assumes: APB3 signalling, 32-bit data, no byte strobes
// Notes:   Out-of-range or misaligned addresses answer with pslverr and read zero
`include "pbs_cfg.svh"

module pbs_apb_slave
	import pbs_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Register side
	pbs_regbus_if.bus        rb
);

	pbs_apb_state_t state;
	pbs_apb_state_t next_state;
	logic [31:0]    next_prdata;
	logic           next_pslverr;
	logic           mapped;

	assign mapped = (paddr[`PBS_SPAN_MSB:`PBS_SPAN_LSB] == 27'h0000000)
		&& (paddr[1:0] == 2'h0);
	assign rb.index = paddr[`PBS_IDX_MSB:`PBS_IDX_LSB];
	assign rb.wdata = pwdata;
	// Writes land at the edge where the master sees pready high
	assign rb.wrStrobe = (state == PBS_ANSWER) && psel && penable && pwrite && mapped;
	// The one-hot answer bit is the flop itself, so pready has no decode behind it
	assign pready = state[1];

	always_comb
	begin
		next_state = state;
		next_prdata = prdata;
		next_pslverr = pslverr;
		case (state)
			PBS_IDLE:
			begin
				if (psel && penable)
				begin
					next_state = PBS_ANSWER;
					next_pslverr = !mapped;
					next_prdata = (mapped && !pwrite) ? rb.rdata : 32'h00000000;
				end
			end
			PBS_ANSWER:
			begin
				next_state = PBS_IDLE;
				next_pslverr = 1'b0;
				next_prdata = 32'h00000000;
			end
			default:
			begin
				next_state = PBS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			state <= PBS_IDLE;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			state <= next_state;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

endmodule

// ===== src/pbs_port_group.sv
// Purpose: One 8-pin parallel port: output data, direction and pin-assignment registers
// Assumes: Pin inputs synchronous to clock
// Notes:   Output data keeps its contents through reset; pin drive follows port mode and output direction one edge late, reset clears it at once
`include "pbs_cfg.svh"

module pbs_port_group
	import pbs_pkg::*;
#(
	parameter int         WIDTH      = `PBS_PORT_WIDTH,
	parameter pbs_index_t IDX_DATA   = `PBS_IDX_PORT_E_DATA,
	parameter pbs_index_t IDX_DIR    = `PBS_IDX_PORT_E_DIR,
	parameter pbs_index_t IDX_ASSIGN = `PBS_IDX_PORT_E_ASSIGN
)
(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Strap level seen during reset
	input  wire logic             strap,
	// Register writes
	input  wire logic             wrStrobe,
	input  wire pbs_index_t       index,
	input  wire logic [31:0]      wdata,
	// Register contents
	output logic [WIDTH-1:0]      outBits,
	output logic [WIDTH-1:0]      dirBits,
	output logic [WIDTH-1:0]      assignBits,
	// Pin drive
	output logic [WIDTH-1:0]      pinOe
);

	logic [WIDTH-1:0] next_outBits;
	logic [WIDTH-1:0] next_dirBits;
	logic [WIDTH-1:0] next_assignBits;
	logic [WIDTH-1:0] next_pinOe;

	always_comb
	begin
		next_outBits = outBits;
		next_dirBits = dirBits;
		next_assignBits = assignBits;
		if (wrStrobe && index == IDX_DATA)
			next_outBits = wdata[WIDTH-1:0];
		if (wrStrobe && index == IDX_DIR)
			next_dirBits = wdata[WIDTH-1:0];
		if (wrStrobe && index == IDX_ASSIGN)
			next_assignBits = wdata[WIDTH-1:0];
		// Registered so the enable comes straight from a flop; lags the control by one edge
		next_pinOe = dirBits & ~assignBits;
	end

	// No reset term: the data latch survives reset untouched
	always_ff @(posedge clock)
	begin
		outBits <= next_outBits; // see RQ2 see RQ4
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			dirBits <= `PBS_DIR_RESET; // see RQ1 see RQ5 see RQ9
			assignBits <= {WIDTH{strap}}; // see RQ3 see RQ6
			pinOe <= '0;
		end
		else
		begin
			dirBits <= next_dirBits;
			assignBits <= next_assignBits;
			pinOe <= next_pinOe;
		end
	end

endmodule

// ===== src/pbs_bank.sv
// Purpose: Reset-state register bank for ports E, F, C and the boot chip-select base
// Assumes: 20 MHz clock, synchronous active-low reset, APB register access
// Notes:   Straps on the data lines are sampled on every clock while reset is held
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "pbs_cfg.svh"

// Notes on behaviour
// RQ1 - Reset clears the port E direction register so all eight port E pins are inputs.
// RQ2 - Reset leaves the port E output data register as it was.
// RQ3 - Each port E assignment bit takes data line eight at reset: 0 port pin, 1 bus control.
// RQ4 - Reset leaves the port F output data register as it was.
// RQ5 - Reset clears the port F direction register so all port F pins are inputs.
// RQ6 - Port F assignment bits load line nine at reset: 0 port, 1 interrupt (pin 0 clock select); clockSelectMode is 0 until one edge after reset.
// RQ7 - Reset sets all seven port C output bits to one.
// RQ8 - Reset clears boot base bits 15 to 3 and sets block size to 111, a 1 Mbyte block.
// RQ9 - All these reset values apply together under system reset, before any software access.
module pbs_bank
	import pbs_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Reset straps
	input  wire logic        bus_line_eight,
	input  wire logic        bus_line_nine,
	// Port E pins
	input  wire logic [7:0]  portEIn,
	output logic [7:0]       portEOut,
	output logic [7:0]       portEOe,
	output logic [7:0]       portEAssign,
	// Port F pins
	input  wire logic [7:0]  portFIn,
	output logic [7:0]       portFOut,
	output logic [7:0]       portFOe,
	output logic [7:0]       portFAssign,
	output logic             clockSelectMode,
	// Port C pins
	output logic [6:0]       portCOut,
	// Boot chip select
	output logic [12:0]      bootBase,
	output logic [2:0]       bootBlockSize
);

	pbs_regbus_if rb ();

	logic [7:0]  port_e_dir_bits;
	logic [7:0]  port_f_dir_bits;
	logic [6:0]  next_portCOut;
	logic [12:0] next_bootBase;
	logic [2:0]  next_bootBlockSize;

	pbs_apb_slave u_apb
	(
		.clock   (clock),
		.reset_n (reset_n),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.pslverr (pslverr),
		.prdata  (prdata),
		.rb      (rb.bus)
	);

	pbs_port_group #(
		.WIDTH      (`PBS_PORT_WIDTH),
		.IDX_DATA   (`PBS_IDX_PORT_E_DATA),
		.IDX_DIR    (`PBS_IDX_PORT_E_DIR),
		.IDX_ASSIGN (`PBS_IDX_PORT_E_ASSIGN)
	) u_port_e
	(
		.clock      (clock),
		.reset_n    (reset_n),
		.strap      (bus_line_eight), // see RQ3
		.wrStrobe   (rb.wrStrobe),
		.index      (rb.index),
		.wdata      (rb.wdata),
		.outBits    (portEOut),
		.dirBits    (port_e_dir_bits),
		.assignBits (portEAssign),
		.pinOe      (portEOe)
	);

	pbs_port_group #(
		.WIDTH      (`PBS_PORT_WIDTH),
		.IDX_DATA   (`PBS_IDX_PORT_F_DATA),
		.IDX_DIR    (`PBS_IDX_PORT_F_DIR),
		.IDX_ASSIGN (`PBS_IDX_PORT_F_ASSIGN)
	) u_port_f
	(
		.clock      (clock),
		.reset_n    (reset_n),
		.strap      (bus_line_nine), // see RQ6
		.wrStrobe   (rb.wrStrobe),
		.index      (rb.index),
		.wdata      (rb.wdata),
		.outBits    (portFOut),
		.dirBits    (port_f_dir_bits),
		.assignBits (portFAssign),
		.pinOe      (portFOe)
	);

	// Read path: port data reads the pin for inputs and the latch for outputs
	always_comb
	begin
		case (rb.index)
			`PBS_IDX_PORT_E_DATA:
				rb.rdata = {24'h000000, (portEIn & ~port_e_dir_bits) | (portEOut & port_e_dir_bits)};
			`PBS_IDX_PORT_E_DIR:
				rb.rdata = {24'h000000, port_e_dir_bits};
			`PBS_IDX_PORT_E_ASSIGN:
				rb.rdata = {24'h000000, portEAssign};
			`PBS_IDX_PORT_F_DATA:
				rb.rdata = {24'h000000, (portFIn & ~port_f_dir_bits) | (portFOut & port_f_dir_bits)};
			`PBS_IDX_PORT_F_DIR:
				rb.rdata = {24'h000000, port_f_dir_bits};
			`PBS_IDX_PORT_F_ASSIGN:
				rb.rdata = {24'h000000, portFAssign};
			`PBS_IDX_PORT_C_DATA:
				rb.rdata = {25'h0000000, portCOut};
			`PBS_IDX_BOOT_BASE:
				rb.rdata = {16'h0000, bootBase, bootBlockSize};
			default:
				rb.rdata = 32'h00000000;
		endcase
	end

	always_comb
	begin
		next_portCOut = portCOut;
		next_bootBase = bootBase;
		next_bootBlockSize = bootBlockSize;
		if (rb.wrStrobe && rb.index == `PBS_IDX_PORT_C_DATA)
			next_portCOut = rb.wdata[`PBS_PORT_C_WIDTH-1:0];
		if (rb.wrStrobe && rb.index == `PBS_IDX_BOOT_BASE)
		begin
			next_bootBase = rb.wdata[`PBS_BASE_MSB:`PBS_BASE_LSB];
			next_bootBlockSize = rb.wdata[`PBS_SIZE_MSB:`PBS_SIZE_LSB];
		end
	end

	// One reset term for every defaulted register of this module, so all land on the same edge
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			portCOut <= `PBS_PORT_C_RESET; // see RQ7 see RQ9
			bootBase <= `PBS_BASE_RESET; // see RQ8
			bootBlockSize <= `PBS_SIZE_RESET; // see RQ8
			clockSelectMode <= 1'b0;
		end
		else
		begin
			portCOut <= next_portCOut;
			bootBase <= next_bootBase;
			bootBlockSize <= next_bootBlockSize;
			// Pin 0 of port F serves the clock-select function one edge after it is assigned; reset holds it off
			clockSelectMode <= portFAssign[0]; // see RQ6
		end
	end

endmodule

// ===== sim/pbs_bank_monitor.sv
// Purpose: Reset-state and APB checks on the port and boot-select bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Reset checks run during reset, so only the APB check is disabled by it
module pbs_bank_monitor
	import pbs_pkg::*;
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// Straps and pins
	input wire logic        bus_line_eight,
	input wire logic        bus_line_nine,
	input wire logic [7:0]  portEOut,
	input wire logic [7:0]  portEOe,
	input wire logic [7:0]  portEAssign,
	input wire logic [7:0]  portFOut,
	input wire logic [7:0]  portFOe,
	input wire logic [7:0]  portFAssign,
	input wire logic [6:0]  portCOut,
	input wire logic [12:0] bootBase,
	input wire logic [2:0]  bootBlockSize
);
	timeunit 1ns;
	timeprecision 1ps;
	logic eSet = 1'b0;
	logic fSet = 1'b0;
	logic done;
	assign done = psel && penable && pready && pwrite;
	// Latches hold X until written, so only written ones are watched
	always_ff @(posedge clock)
	begin
		if (done && paddr == 32'h0000_0000)
			eSet <= 1'b1;
		if (done && paddr == 32'h0000_000C)
			fSet <= 1'b1;
	end
	property p_dir_e;
		@(posedge clock) !reset_n |=> portEOe == 8'h00;
	endproperty
	a_dir_e: assert property (p_dir_e) else $error("port E driven in reset");
	property p_dir_f;
		@(posedge clock) !reset_n |=> portFOe == 8'h00;
	endproperty
	a_dir_f: assert property (p_dir_f) else $error("port F driven in reset");
	property p_asg_e;
		@(posedge clock) !reset_n |=> portEAssign == {8{$past(bus_line_eight)}};
	endproperty
	a_asg_e: assert property (p_asg_e) else $error("port E assign wrong");
	property p_asg_f;
		@(posedge clock) !reset_n |=> portFAssign == {8{$past(bus_line_nine)}};
	endproperty
	a_asg_f: assert property (p_asg_f) else $error("port F assign wrong");
	property p_port_c;
		@(posedge clock) !reset_n |=> portCOut == 7'h7F;
	endproperty
	a_port_c: assert property (p_port_c) else $error("port C not set");
	property p_boot;
		@(posedge clock) !reset_n |=> bootBase == 13'h0000 && bootBlockSize == 3'h7;
	endproperty
	a_boot: assert property (p_boot) else $error("boot base wrong");
	property p_keep_e;
		@(posedge clock) !reset_n && eSet |=> $stable(portEOut);
	endproperty
	a_keep_e: assert property (p_keep_e) else $error("port E data lost");
	property p_keep_f;
		@(posedge clock) !reset_n && fSet |=> $stable(portFOut);
	endproperty
	a_keep_f: assert property (p_keep_f) else $error("port F data lost");
	property p_answer;
		@(posedge clock) disable iff (!reset_n)
			psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer) else $error("bad APB answer");
	c_err: cover property (@(posedge clock) pready && pslverr);
	c_keep: cover property (@(posedge clock) !reset_n && eSet && fSet);
	c_write: cover property (@(posedge clock) done);
endmodule

bind pbs_bank pbs_bank_monitor i_mon
(
	.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .bus_line_eight(bus_line_eight),
	.bus_line_nine(bus_line_nine), .portEOut(portEOut), .portEOe(portEOe),
	.portEAssign(portEAssign), .portFOut(portFOut), .portFOe(portFOe),
	.portFAssign(portFAssign), .portCOut(portCOut), .bootBase(bootBase),
	.bootBlockSize(bootBlockSize)
);

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the port and boot-select bank
// Assumes: 20 MHz clock, APB master driven on rising edges
// Notes:   Latches are X until written, so reset-keep checks write first
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pbs_pkg::*;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        s8 = 1'b0;
	logic        s9 = 1'b0;
	logic [7:0]  eIn = 8'h5A;
	logic [7:0]  fIn = 8'hC3;
	logic [7:0]  eOut, eOe, eAsg, fOut, fOe, fAsg;
	logic        clkSel;
	logic [6:0]  cOut;
	logic [12:0] base;
	logic [2:0]  size;
	logic [31:0] rd;
	logic        er;
	int          failures = 0;
	int          compares = 0;
	initial forever #25 clock = ~clock;
	pbs_bank i_dut
	(
		.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .bus_line_eight(s8), .bus_line_nine(s9),
		.portEIn(eIn), .portEOut(eOut), .portEOe(eOe), .portEAssign(eAsg),
		.portFIn(fIn), .portFOut(fOut), .portFOe(fOe), .portFAssign(fAsg),
		.clockSelectMode(clkSel), .portCOut(cOut), .bootBase(base),
		.bootBlockSize(size)
	);
	task complete_run();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task rst(input logic a, input logic b);
		reset_n <= 1'b0;
		s8 <= a;
		s9 <= b;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			failures++;
			complete_run();
		end
		else
		begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clock);
		end
	endtask
	task t_reset_values();
		rst(1'b1, 1'b0);
		`CHK(eAsg, 8'hFF)
		`CHK(fAsg, 8'h00)
		`CHK(cOut, 7'h7F)
		apb(1'b0, 32'h04, 32'h0);
		`CHK(rd, 32'h00)
		apb(1'b0, 32'h10, 32'h0);
		`CHK(rd, 32'h00)
		apb(1'b0, 32'h18, 32'h0);
		`CHK(rd, 32'h7F)
		apb(1'b0, 32'h1C, 32'h0);
		`CHK(rd, 32'h07)
		apb(1'b0, 32'h08, 32'h0);
		`CHK(rd, 32'hFF)
		apb(1'b0, 32'h14, 32'h0);
		`CHK(rd, 32'h00)
		rst(1'b0, 1'b1);
		apb(1'b0, 32'h08, 32'h0);
		`CHK(rd, 32'h00)
		apb(1'b0, 32'h14, 32'h0);
		`CHK(rd, 32'hFF)
		`CHK(clkSel, 1'b1)
	endtask
	task t_keep_data();
		apb(1'b1, 32'h00, 32'hA5);
		apb(1'b1, 32'h0C, 32'h3C);
		apb(1'b1, 32'h04, 32'hFF);
		apb(1'b1, 32'h10, 32'hFF);
		apb(1'b1, 32'h1C, 32'hABCD);
		`CHK(eOe, 8'hFF)
		rst(1'b1, 1'b1);
		`CHK(fOe, 8'h00)
		`CHK(eOut, 8'hA5)
		`CHK(fOut, 8'h3C)
		`CHK(eOe, 8'h00)
		`CHK({base, size}, 16'h0007)
		apb(1'b0, 32'h00, 32'h0);
		`CHK(rd, 32'h5A)
		apb(1'b0, 32'h0C, 32'h0);
		`CHK(rd, 32'hC3)
	endtask
	task t_refuse();
		apb(1'b1, 32'h20, 32'h12);
		`CHK(er, 1'b1)
		`CHK(eOut, 8'hA5)
		apb(1'b0, 32'h1A, 32'h0);
		`CHK({er, rd}, 33'h100000000)
	endtask
	initial
	begin
		t_reset_values();
		t_keep_data();
		t_refuse();
		complete_run();
	end
endmodule
